// File: fwd_clock_gen.v
`timescale 1ns/1ps
`include "tx_serializer_consts.vh"
// forwarded clock pattern, sampled per bit slot; divided modes shift phase by eighths of the period, rounded down
module fwd_clock_gen
(
   // clock and reset
   input  wire                  core_clk,
   input  wire                  rst_n,
   // configuration
   input  wire [2:0]            divSel,
   input  wire [2:0]            phaseSel,
   input  wire                  wordStart,
   // output
   output reg                   clkBit
);
   reg  [3:0] halfLen;
   reg  [4:0] cnt_reg;
   reg  [4:0] cnt_next;
   wire [4:0] period;
   wire [4:0] shifted;
   wire [7:0] phaseOff;
   wire [5:0] phaseSum;
   wire [5:0] wrapSum;

   always @*
   begin
      case (divSel)
         `DIV_2:  halfLen = 4'h2;
         `DIV_4:  halfLen = 4'h4;
         `DIV_6:  halfLen = 4'h6;
         `DIV_8:  halfLen = 4'h8;
         `DIV_10: halfLen = 4'hA;
         default: halfLen = 4'h1;
      endcase
   end

   assign period = {halfLen, 1'b0};

   // free running from reset, which already lines the first edge up with the first word;
   // realigning at every word start would stall any period longer than one word
   always @*
   begin
      if (cnt_reg >= period - 5'h1)
         cnt_next = 5'h0;
      else
         cnt_next = cnt_reg + 5'h1;
   end

   always @(posedge core_clk)
   begin
      if (!rst_n)
         cnt_reg <= 5'h0;
      else
         cnt_reg <= cnt_next;
   end

   // phase offset in bit slots: period * phase / 8, rounded down
   assign phaseOff = ({3'h0, period} * {5'h0, phaseSel}) >> 3; // RULE8
   // six bits: count plus offset passes 31 at the slowest divide
   assign phaseSum = {1'b0, cnt_reg} + {1'b0, phaseOff[4:0]};
   assign wrapSum  = (phaseSum >= {1'b0, period}) ? phaseSum - {1'b0, period} : phaseSum;
   assign shifted  = wrapSum[4:0];

   always @(posedge core_clk)
   begin
      if (!rst_n)
         clkBit <= 1'b0;
      else if (divSel == `DIV_FULL)
         clkBit <= ~clkBit; // RULE7
      else
         clkBit <= (shifted < {1'b0, halfLen}); // RULE7
   end
endmodule // fwd_clock_gen

// File: link_receiver.sv
`timescale 1ns/1ps
module link_receiver
(
   // link side
   input  wire core_clk,
   input  wire lineIn,
   // recovered bit
   output reg  rxBit
);
   // one sample per bit slot; word framing is left to the bench
   always @(posedge core_clk)
      rxBit <= lineIn;
endmodule // link_receiver

// File: load_strobe_gen.v
`timescale 1ns/1ps
// one-cycle load strobe, once every factor bit-clock cycles
module load_strobe_gen
(
   // clock and reset
   input  wire                  core_clk,
   input  wire                  rst_n,
   // configuration
   input  wire [3:0]            factor,
   // strobe
   output wire                  loadStrobe,
   output wire [3:0]            bitIndex
);
   reg  [3:0] cnt_reg;
   reg  [3:0] cnt_next;

   always @*
   begin
      if (cnt_reg >= factor - 4'h1)
         cnt_next = 4'h0;
      else
         cnt_next = cnt_reg + 4'h1;
   end

   always @(posedge core_clk)
   begin
      if (!rst_n)
         cnt_reg <= 4'h0;
      else
         cnt_reg <= cnt_next;
   end

   assign loadStrobe = (cnt_reg == 4'h0); // RULE5 RULE13
   assign bitIndex   = cnt_reg;
endmodule // load_strobe_gen

// File: testbench.sv
`timescale 1ns/1ps
`include "tx_serializer_consts.vh"
module testbench;
   reg        core_clk = 1'b0;
   reg        rst_n = 1'b0;
   reg  [1:0] chanMode = 2'h0;
   reg  [3:0] serFactor = 4'h4;
   reg  [2:0] clkDivSel = 3'h0;
   reg  [2:0] clkPhaseSel = 3'h0;
   reg  [9:0] txWord = 10'h000;
   reg  [1:0] bypassData = 2'h0;
   wire       wordLoad, factorValid, serialOut, outHalf, rxBit;
   reg        live = 1'b0;
   reg  [1:0] expQ[$];
   reg  [1:0] e;
   integer    err_count = 0;
   integer    checked = 0;
   integer    i, k, n, b, r, h, off;
   tx_serializer u_dut (.core_clk(core_clk), .rst_n(rst_n), .chanMode(chanMode), .serFactor(serFactor),
      .clkDivSel(clkDivSel), .clkPhaseSel(clkPhaseSel), .txWord(txWord), .bypassData(bypassData),
      .wordLoad(wordLoad), .factorValid(factorValid), .serialOut(serialOut), .outHalf(outHalf));
   link_receiver u_rx (.core_clk(core_clk), .lineIn(serialOut), .rxBit(rxBit));
   always #12.5 core_clk = ~core_clk;
   always @(posedge core_clk)
      live <= rst_n;
   // bit 1 of a note marks a slot worth checking
   always @(negedge core_clk)
      if (live && expQ.size() > 0)
      begin
         e = expQ.pop_front();
         if (e[1])
         begin
            checked = checked + 1;
            if (rxBit !== e[0])
            begin
               err_count = err_count + 1;
               $display("BAD %0t serial bit %b", $time, rxBit);
            end
         end
      end
   task start(input [1:0] m, input [3:0] f, input [2:0] d, input integer sk);
      begin
         rst_n = 1'b0;
         chanMode = m;
         serFactor = f;
         clkDivSel = d;
         clkPhaseSel = d;
         repeat (16) @(negedge core_clk);
         // skip notes go in only once the checker has gone idle in reset
         repeat (sk) expQ.push_back(2'b00);
         rst_n = 1'b1;
      end
   endtask
   task drain;
      begin
         for (k = 0; k < 40 && expQ.size() > 0; k = k + 1)
            @(negedge core_clk);
         if (expQ.size() > 0)
         begin
            err_count = err_count + 1;
            $display("BAD %0t results missing", $time);
            expQ.delete();
         end
      end
   endtask
   task complete_run;
      begin
         if (err_count == 0 && checked > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   initial
   begin
      #(25 * 4000);
      err_count = err_count + 1;
      complete_run;
   end
   initial
   begin
      n = $urandom(19873);
      // last pass uses an illegal factor, which must behave as ten
      for (i = 3; i < 12; i = i + 1)
      begin
         n = (i == 11) ? 10 : i;
         start(`MODE_SERIAL, (i == 11) ? 4'hF : i[3:0], 3'h0, n + 1);
         checked = checked + 1;
         if (factorValid !== (i != 11))
         begin
            err_count = err_count + 1;
            $display("BAD %0t factor flag %b", $time, factorValid);
         end
         for (k = 0; k < 6 * n; k = k + 1)
         begin
            r = $urandom;
            txWord = r[9:0];
            if (wordLoad === 1'b1)
               for (b = n - 1; b >= 0; b = b - 1)
                  expQ.push_back({1'b1, txWord[b]});
            @(negedge core_clk);
         end
         drain;
      end
      // half period in bit slots is the divide factor; phase offset is eighths of the period
      for (i = 0; i < 7; i = i + 1)
      begin
         start(`MODE_CLKOUT, 4'h4, i[2:0], 1);
         h = (i == 1) ? 1 : (i - 1) * 2;
         off = (2 * h * i) / 8;
         for (k = 0; k < 24; k = k + 1)
            if (i == 0)
               expQ.push_back({1'b1, k[0] == 1'b0});
            else
               expQ.push_back({1'b1, ((k + off) % (2 * h)) < h});
         drain;
      end
      // double rate needs one skip slot while the first pair is registered
      for (i = 2; i < 4; i = i + 1)
      begin
         start(i[1:0], 4'h4, 3'h0, (i == 2) ? 1 : 0);
         for (k = 0; k < 24; k = k + 1)
         begin
            r = $urandom;
            bypassData = r[1:0];
            if (i == 3)
               expQ.push_back({1'b1, r[0]});
            else if (k[0] == 1'b0)
            begin
               expQ.push_back({1'b1, r[1]});
               expQ.push_back({1'b1, r[0]});
            end
            @(negedge core_clk);
         end
         drain;
      end
      complete_run;
   end
endmodule // testbench
bind tx_serializer tx_serializer_chk u_chk (.core_clk(core_clk), .rst_n(rst_n), .chanMode(chanMode),
   .serFactor(serFactor), .clkDivSel(clkDivSel), .clkPhaseSel(clkPhaseSel), .txWord(txWord),
   .bypassData(bypassData), .wordLoad(wordLoad), .factorValid(factorValid), .serialOut(serialOut),
   .outHalf(outHalf));

// File: tx_serializer.v
`timescale 1ns/1ps
`include "tx_serializer_consts.vh"
// Notes on behaviour
// RULE1: a parallel word of up to ten bits is captured into the load register before shifting.
// RULE2: each word leaves most significant bit first and least significant bit last.
// RULE3: load and shift registers run on the bit clock, capture gated by the load strobe.
// RULE4: the serialization factor is a static setting from 3 to 10.
// RULE5: the load strobe period and position follow from the factor, one word per word time.
// RULE6: any channel may instead send a forwarded clock.
// RULE7: the forwarded clock runs at the data rate or divided by 1, 2, 4, 6, 8 or 10.
// RULE8: the forwarded clock phase steps in 45 degree increments; code rounds eighths of the period down to slots, none at DIV_FULL.
// RULE9: in bypass the channel offers double rate (factor 2) and single rate (factor 1).
// RULE10: two output registers, each usable in double or single rate bypass; code registers only double rate, in ddr_reg.
// RULE11: single rate passes one bit straight through, double rate registers two bits.
// RULE12: single rate bypass does not register the bit.
// RULE13: the load strobe lasts one bit-clock cycle per word and moves load into shift that cycle.
module tx_serializer
(
   // clock and reset
   input  wire                  core_clk,
   input  wire                  rst_n,
   // static configuration
   input  wire [1:0]            chanMode,
   input  wire [3:0]            serFactor,
   input  wire [2:0]            clkDivSel,
   input  wire [2:0]            clkPhaseSel,
   // parallel data from the core
   input  wire [9:0]            txWord,
   input  wire [1:0]            bypassData,
   // word timing
   output wire                  wordLoad,
   output wire                  factorValid,
   // serial output
   output wire                  serialOut,
   output reg                   outHalf
);
   wire [3:0] factor;
   wire [3:0] bitIndex;
   wire       clkBit;
   reg  [9:0] load_reg;
   reg  [9:0] shift_reg;
   reg  [9:0] shift_next;
   reg        serBit_reg;
   reg  [1:0] ddr_reg;
   reg        ddrPhase_reg;
   reg        bitOut;

   // out-of-range factor falls back to 10 so the strobe never stalls
   assign factorValid = (serFactor >= `FACTOR_MIN) && (serFactor <= `FACTOR_MAX); // RULE4
   assign factor      = factorValid ? serFactor : `FACTOR_RST;

   load_strobe_gen u_strobe
   (
      .core_clk   (core_clk),
      .rst_n      (rst_n),
      .factor     (factor),
      .loadStrobe (wordLoad),
      .bitIndex   (bitIndex)
   );

   fwd_clock_gen u_fwdclk
   (
      .core_clk   (core_clk),
      .rst_n      (rst_n),
      .divSel     (clkDivSel),
      .phaseSel   (clkPhaseSel),
      .wordStart  (wordLoad),
      .clkBit     (clkBit)
   );

   // capture: the core presents txWord in the strobe cycle
   always @(posedge core_clk)
   begin
      if (!rst_n)
         load_reg <= 10'h000;
      else if (wordLoad)
         load_reg <= txWord; // RULE1 RULE3
   end

   // word is left-aligned so bit 9 is always the next one out
   always @*
   begin
      if (wordLoad)
         shift_next = load_reg << (`WORD_W - factor); // RULE13
      else
         shift_next = {shift_reg[8:0], 1'b0}; // RULE2
   end

   always @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         shift_reg  <= 10'h000;
         serBit_reg <= 1'b0;
      end
      else
      begin
         shift_reg  <= shift_next; // RULE3
         serBit_reg <= shift_next[9]; // RULE2
      end
   end

   // double rate: two bits held per cycle pair, high bit first
   always @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         ddr_reg      <= 2'h0;
         ddrPhase_reg <= 1'b0;
         outHalf      <= 1'b0;
      end
      else
      begin
         ddrPhase_reg <= ~ddrPhase_reg;
         outHalf      <= ddrPhase_reg;
         if (!ddrPhase_reg)
            ddr_reg <= bypassData; // RULE9 RULE10 RULE11
      end
   end

   always @*
   begin
      case (chanMode)
         `MODE_SERIAL: bitOut = serBit_reg;
         `MODE_CLKOUT: bitOut = clkBit; // RULE6
         `MODE_DDR:    bitOut = outHalf ? ddr_reg[0] : ddr_reg[1]; // RULE11
         `MODE_SDR:    bitOut = bypassData[0]; // RULE12
         default:      bitOut = 1'b0;
      endcase
   end

   assign serialOut = bitOut;
endmodule // tx_serializer

// File: tx_serializer_consts.vh
`ifndef TX_SERIALIZER_CONSTS_VH
`define TX_SERIALIZER_CONSTS_VH

// parallel word width and factor limits
`define WORD_W          10
`define FACTOR_W        4
`define FACTOR_MIN      4'h3
`define FACTOR_MAX      4'hA
`define FACTOR_RST      4'hA

// channel modes
`define MODE_W          2
`define MODE_SERIAL     2'h0
`define MODE_CLKOUT     2'h1
`define MODE_DDR        2'h2
`define MODE_SDR        2'h3

// forwarded clock divide codes
`define DIV_W           3
`define DIV_FULL        3'h0
`define DIV_1           3'h1
`define DIV_2           3'h2
`define DIV_4           3'h3
`define DIV_6           3'h4
`define DIV_8           3'h5
`define DIV_10          3'h6

// forwarded clock phase, in 45 degree steps over 8 sub-phases
`define PHASE_W         3
`define PHASE_STEPS     4'h8

`endif

// File: tx_serializer_properties.sv
`timescale 1ns/1ps
`include "tx_serializer_consts.vh"
module tx_serializer_chk
(
   // inputs
   input wire       core_clk,
   input wire       rst_n,
   input wire [1:0] chanMode,
   input wire [3:0] serFactor,
   input wire [2:0] clkDivSel,
   input wire [2:0] clkPhaseSel,
   input wire [9:0] txWord,
   input wire [1:0] bypassData,
   // outputs
   input wire       wordLoad,
   input wire       factorValid,
   input wire       serialOut,
   input wire       outHalf
);
   reg [3:0] slot;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // preset in reset so the first strobe lands on the first free cycle
   always @(posedge core_clk)
      slot <= !rst_n ? serFactor - 4'h1 : (slot == serFactor - 4'h1 ? 4'h0 : slot + 4'h1);
   a_factor_range: assert property (factorValid == (serFactor >= `FACTOR_MIN && serFactor <= `FACTOR_MAX))
      else $error("factor flag wrong");
   a_strobe_slot: assert property (factorValid |-> wordLoad == (slot == serFactor - 4'h1))
      else $error("strobe off its slot");
   a_strobe_single: assert property (wordLoad |=> !wordLoad)
      else $error("strobe too long");
   a_msb_first: assert property (chanMode == `MODE_SERIAL && serFactor == 4'h4 && $past(rst_n, 5)
      && $past(wordLoad) && $past(wordLoad, 5) |-> serialOut == $past(txWord[3], 5)
      ##3 serialOut == $past(txWord[0], 8)) else $error("bit order wrong");
   a_sdr_pass: assert property (chanMode == `MODE_SDR |-> serialOut == bypassData[0])
      else $error("sdr not passed through");
   a_ddr_pairs: assert property (chanMode == `MODE_DDR && !outHalf && $past(rst_n)
      |-> serialOut == $past(bypassData[1]) ##1 serialOut == $past(bypassData[0], 2)) else $error("ddr pair wrong");
   a_ddr_halves: assert property (chanMode == `MODE_DDR && $past(rst_n, 2) |-> outHalf != $past(outHalf))
      else $error("ddr half stuck");
   a_clk_toggle: assert property (chanMode == `MODE_CLKOUT && clkDivSel <= `DIV_1 && clkPhaseSel == 3'h0
      && serFactor == 4'h4 && $past(rst_n, 2) |-> serialOut != $past(serialOut)) else $error("clock not toggling");
endmodule // tx_serializer_chk
